//--- design/mbfd_decoder.sv
// mbfd_decoder: checks a parsed request and drives register access
// assumes framing upstream; register store answers reads combinationally
// How it works
// - code 01 reads output bits, quantity 1 to 256
// - code 02 reads input bits, quantity 1 to 256
// - code 03 reads consecutive words, quantity 1 to 100
// - code 05 writes exactly one bit from the request value
// - code 06 writes exactly one word from the request value
// - code 0F writes consecutive bits, quantity 1 to 256
// - code 10 writes consecutive words, quantity 1 to 100
// - unknown code gives exception 01, bad address gives exception 02
// - quantity outside 1..limit, byte count mismatch or bad single bit value gives exception 03
`timescale 1ns/1ps
`include "mbfd_consts.svh"
module mbfd_decoder
    import mbfd_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // request, held stable while req_valid_i is high
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [7:0] req_func_i,
    input wire logic [15:0] req_addr_i,
    input wire logic [15:0] req_qty_i,
    input wire logic [7:0] req_bytes_i,
    input wire logic [15:0] req_value_i,
    // write data per item, indexed by wr_idx_o
    output logic [15:0] wr_idx_o,
    input wire logic [15:0] wr_word_i,
    input wire logic wr_bit_i,
    // register store
    output logic reg_bit_o,
    output logic reg_rd_o,
    output logic reg_we_o,
    output logic [15:0] reg_addr_o,
    output logic [15:0] reg_wdata_o,
    input wire logic [15:0] reg_rdata_i,
    // read data stream
    output logic rd_valid_o,
    output logic [15:0] rd_data_o,
    // response header
    output logic rsp_valid_o,
    input wire logic rsp_ready_i,
    output logic [7:0] rsp_func_o,
    output logic rsp_exc_o,
    output logic [7:0] rsp_code_o
);
    mbfd_state_e st_q, st_d;
    mbfd_acc_e acc_q, acc_d;
    logic [7:0] func_q, func_d, code_q, code_d;
    logic [15:0] value_q, value_d;
    logic rdv_q, rdv_d;
    logic [15:0] rdd_q, rdd_d;
    logic single_q, single_d;
    logic [7:0] exc;
    mbfd_acc_e acc;
    logic start, w_busy, w_last;
    logic [15:0] w_addr, w_idx;

    // true when quantity sits in 1..max
    function automatic logic qty_ok(input logic [15:0] q,
                                    input logic [15:0] mx);
        qty_ok = (q != 16'h0000) && (q <= mx);
    endfunction : qty_ok

    // true when the run stays inside the address space
    function automatic logic span_ok(input logic [15:0] a,
                                     input logic [15:0] q,
                                     input logic [16:0] sp);
        span_ok = ({1'b0, a} + {1'b0, q}) <= sp;
    endfunction : span_ok

    // byte count expected for a multiple bit write
    function automatic logic [15:0] bit_bytes(input logic [15:0] q);
        bit_bytes = (q + 16'h0007) >> 3;
    endfunction : bit_bytes

    // classify the request; exception order is code, length, address
    // over-limit lengths give code 03
    always_comb begin
        exc = 8'h00;
        acc = MBFD_ACC_NONE;
        case (req_func_i)
            `MBFD_FC_RD_COILS, `MBFD_FC_RD_BITS: begin
                // input bit read shares the bit limit
                acc = MBFD_ACC_RD_BIT;
                if (!qty_ok(req_qty_i, `MBFD_MAX_BITS)) begin
                    exc = `MBFD_EX_LEN;
                end else if (!span_ok(req_addr_i, req_qty_i,
                                      `MBFD_BIT_SPACE)) begin
                    exc = `MBFD_EX_ADDR;
                end
            end
            `MBFD_FC_RD_WORDS: begin
                acc = MBFD_ACC_RD_WORD;
                if (!qty_ok(req_qty_i, `MBFD_MAX_WORDS)) begin
                    exc = `MBFD_EX_LEN;
                end else if (!span_ok(req_addr_i, req_qty_i,
                                      `MBFD_WORD_SPACE)) begin
                    exc = `MBFD_EX_ADDR;
                end
            end
            // single bit write, value must be on or off
            `MBFD_FC_WR_BIT: begin
                acc = MBFD_ACC_WR_BIT;
                if (req_value_i != `MBFD_COIL_ON &&
                    req_value_i != `MBFD_COIL_OFF) begin
                    exc = `MBFD_EX_LEN;
                end
            end
            `MBFD_FC_WR_WORD: begin
                acc = MBFD_ACC_WR_WORD;
            end
            // multiple bit write, byte count must match
            `MBFD_FC_WR_BITS: begin
                acc = MBFD_ACC_WR_BIT;
                if (!qty_ok(req_qty_i, `MBFD_MAX_BITS) ||
                    bit_bytes(req_qty_i) != {8'h00, req_bytes_i}) begin
                    exc = `MBFD_EX_LEN;
                end else if (!span_ok(req_addr_i, req_qty_i,
                                      `MBFD_BIT_SPACE)) begin
                    exc = `MBFD_EX_ADDR;
                end
            end
            // multiple word write, two bytes per word
            `MBFD_FC_WR_WORDS: begin
                acc = MBFD_ACC_WR_WORD;
                if (!qty_ok(req_qty_i, `MBFD_MAX_WORDS) ||
                    {req_qty_i[14:0], 1'b0} != {8'h00, req_bytes_i})
                begin
                    exc = `MBFD_EX_LEN;
                end else if (!span_ok(req_addr_i, req_qty_i,
                                      `MBFD_WORD_SPACE)) begin
                    exc = `MBFD_EX_ADDR;
                end
            end
            default: begin
                exc = `MBFD_EX_FUNC;
            end
        endcase
    end

    logic single;
    assign single = (req_func_i == `MBFD_FC_WR_BIT) ||
                    (req_func_i == `MBFD_FC_WR_WORD);
    assign req_ready_o = (st_q == MBFD_IDLE);
    // walk starts only for a clean request
    assign start = req_valid_i && (st_q == MBFD_IDLE) && (exc == 8'h00);

    mbfd_walker u_walker (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .start_i(start),
        .addr_i(req_addr_i),
        .qty_i(single ? 16'h0001 : req_qty_i),
        .busy_o(w_busy),
        .addr_o(w_addr),
        .idx_o(w_idx),
        .last_o(w_last)
    );

    always_comb begin
        st_d = st_q;
        acc_d = acc_q;
        func_d = func_q;
        code_d = code_q;
        value_d = value_q;
        single_d = single_q;
        rdv_d = 1'b0;
        rdd_d = rdd_q;
        case (st_q)
            MBFD_IDLE: begin
                if (req_valid_i) begin
                    func_d = req_func_i;
                    code_d = exc;
                    acc_d = acc;
                    value_d = req_value_i;
                    single_d = single;
                    st_d = (exc != 8'h00) ? MBFD_EXC : MBFD_RUN;
                end
            end
            MBFD_RUN: begin
                if (acc_q == MBFD_ACC_RD_BIT ||
                    acc_q == MBFD_ACC_RD_WORD) begin
                    rdv_d = 1'b1;
                    rdd_d = reg_rdata_i;
                end
                if (w_last) begin
                    st_d = MBFD_RESP;
                end
            end
            MBFD_RESP, MBFD_EXC: begin
                if (rsp_ready_i) begin
                    st_d = MBFD_IDLE;
                end
            end
            default: begin
                st_d = MBFD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= MBFD_IDLE;
            acc_q <= MBFD_ACC_NONE;
            func_q <= 8'h00;
            code_q <= 8'h00;
            value_q <= 16'h0000;
            single_q <= 1'b0;
            rdv_q <= 1'b0;
            rdd_q <= 16'h0000;
        end else if (ce_i) begin
            st_q <= st_d;
            acc_q <= acc_d;
            func_q <= func_d;
            code_q <= code_d;
            value_q <= value_d;
            single_q <= single_d;
            rdv_q <= rdv_d;
            rdd_q <= rdd_d;
        end
    end

    // register port follows the walker
    assign wr_idx_o = w_idx;
    assign reg_addr_o = w_addr;
    assign reg_bit_o = (acc_q == MBFD_ACC_RD_BIT) ||
                       (acc_q == MBFD_ACC_WR_BIT);
    assign reg_rd_o = (st_q == MBFD_RUN) && w_busy &&
                      (acc_q == MBFD_ACC_RD_BIT ||
                       acc_q == MBFD_ACC_RD_WORD);
    // writes only in the run state
    assign reg_we_o = ce_i && (st_q == MBFD_RUN) && w_busy &&
                      (acc_q == MBFD_ACC_WR_BIT ||
                       acc_q == MBFD_ACC_WR_WORD);
    // single values come from the request itself
    assign reg_wdata_o = !single_q ?
        ((acc_q == MBFD_ACC_WR_BIT) ? {15'h0000, wr_bit_i} : wr_word_i) :
        ((acc_q == MBFD_ACC_WR_BIT) ?
            {15'h0000, value_q == `MBFD_COIL_ON} : value_q);
    assign rd_valid_o = rdv_q;
    assign rd_data_o = rdd_q;

    assign rsp_valid_o = (st_q == MBFD_RESP) || (st_q == MBFD_EXC);
    assign rsp_exc_o = (st_q == MBFD_EXC);
    assign rsp_func_o = (st_q == MBFD_EXC) ? (func_q | `MBFD_EX_FLAG)
                                           : func_q;
    assign rsp_code_o = (st_q == MBFD_EXC) ? code_q : 8'h00;

    unsupported_fc_a: assert property (@(posedge mclk_i) disable iff
        (!rst_n_i) (ce_i && req_ready_o && req_valid_i && !single &&
        acc == MBFD_ACC_NONE) |=> (rsp_exc_o && rsp_code_o ==
        `MBFD_EX_FUNC)) else $error("bad code not refused");
    exc_func_a: assert property (@(posedge mclk_i) disable iff
        (!rst_n_i) rsp_exc_o |-> rsp_func_o[7] &&
        rsp_func_o[6:0] == func_q[6:0]) else $error("bad exc echo");
    normal_echo_a: assert property (@(posedge mclk_i) disable iff
        (!rst_n_i) (rsp_valid_o && !rsp_exc_o) |-> rsp_func_o == func_q)
        else $error("bad echo");
    no_write_exc_a: assert property (@(posedge mclk_i) disable iff
        (!rst_n_i) rsp_exc_o |-> !reg_we_o)
        else $error("write during exception");
    word_limit_a: assert property (@(posedge mclk_i) disable iff
        (!rst_n_i) (ce_i && req_ready_o && req_valid_i &&
        req_func_i == `MBFD_FC_RD_WORDS && req_qty_i > `MBFD_MAX_WORDS)
        |=> rsp_code_o == `MBFD_EX_LEN) else $error("word limit");
    bit_limit_a: assert property (@(posedge mclk_i) disable iff
        (!rst_n_i) (ce_i && req_ready_o && req_valid_i &&
        req_func_i == `MBFD_FC_RD_COILS && req_qty_i > `MBFD_MAX_BITS)
        |=> rsp_code_o == `MBFD_EX_LEN) else $error("bit limit");
    single_wr_a: assert property (@(posedge mclk_i) disable iff
        (!rst_n_i) (ce_i && start && single) |=> reg_we_o ##1 !reg_we_o)
        else $error("single write count");
    read_stream_a: assert property (@(posedge mclk_i) disable iff
        (!rst_n_i) (ce_i && reg_rd_o) |=> rd_valid_o)
        else $error("read data missing");
    cov_exc_c: cover property (@(posedge mclk_i) rsp_exc_o);
    cov_rd_c: cover property (@(posedge mclk_i) rsp_valid_o &&
        func_q == `MBFD_FC_RD_WORDS);
    cov_wr_c: cover property (@(posedge mclk_i) rsp_valid_o &&
        func_q == `MBFD_FC_WR_BITS && !rsp_exc_o);
endmodule : mbfd_decoder

//--- design/mbfd_consts.svh
// mbfd_consts.svh: function codes, exception codes, limits and sizes
// assumes inclusion by bare name from the decoder and walker modules
`ifndef MBFD_CONSTS_SVH
`define MBFD_CONSTS_SVH
`define MBFD_FC_RD_COILS 8'h01
`define MBFD_FC_RD_BITS 8'h02
`define MBFD_FC_RD_WORDS 8'h03
`define MBFD_FC_WR_BIT 8'h05
`define MBFD_FC_WR_WORD 8'h06
`define MBFD_FC_WR_BITS 8'h0f
`define MBFD_FC_WR_WORDS 8'h10
`define MBFD_EX_FUNC 8'h01
`define MBFD_EX_ADDR 8'h02
`define MBFD_EX_LEN 8'h03
`define MBFD_EX_FLAG 8'h80
`define MBFD_MAX_BITS 16'h0100
`define MBFD_MAX_WORDS 16'h0064
`define MBFD_BIT_SPACE 17'h10000
`define MBFD_WORD_SPACE 17'h10000
`define MBFD_COIL_ON 16'hff00
`define MBFD_COIL_OFF 16'h0000
`endif

//--- design/mbfd_pkg.sv
// mbfd_pkg: types shared by the decoder and its access engine
// numeric values are written inline; mbfd_consts.svh is not used here
package mbfd_pkg;
    typedef enum logic [3:0] {
        MBFD_ACC_NONE = 4'h0,
        MBFD_ACC_RD_BIT = 4'h1,
        MBFD_ACC_RD_WORD = 4'h2,
        MBFD_ACC_WR_BIT = 4'h4,
        MBFD_ACC_WR_WORD = 4'h8
    } mbfd_acc_e;
    typedef enum logic [3:0] {
        MBFD_IDLE = 4'b0001,
        MBFD_RUN = 4'b0010,
        MBFD_RESP = 4'b0100,
        MBFD_EXC = 4'b1000
    } mbfd_state_e;
endpackage : mbfd_pkg

//--- design/mbfd_walker.sv
// mbfd_walker: steps a register address over a run of items
// assumes a start pulse only while idle; one item per enabled clock
`timescale 1ns/1ps
`include "mbfd_consts.svh"
module mbfd_walker
    import mbfd_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // control
    input wire logic start_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] qty_i,
    // walk
    output logic busy_o,
    output logic [15:0] addr_o,
    output logic [15:0] idx_o,
    output logic last_o
);
    logic [15:0] left_q, left_d, addr_q, addr_d, idx_q, idx_d;
    logic busy_q, busy_d;

    always_comb begin
        left_d = left_q;
        addr_d = addr_q;
        idx_d = idx_q;
        busy_d = busy_q;
        if (start_i && !busy_q) begin
            left_d = qty_i;
            addr_d = addr_i;
            idx_d = 16'h0000;
            busy_d = 1'b1;
        end else if (busy_q) begin
            left_d = left_q - 16'h0001;
            addr_d = addr_q + 16'h0001;
            idx_d = idx_q + 16'h0001;
            if (left_q == 16'h0001) begin
                busy_d = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_q <= 16'h0000;
            addr_q <= 16'h0000;
            idx_q <= 16'h0000;
            busy_q <= 1'b0;
        end else if (ce_i) begin
            left_q <= left_d;
            addr_q <= addr_d;
            idx_q <= idx_d;
            busy_q <= busy_d;
        end
    end

    assign busy_o = busy_q;
    assign addr_o = addr_q;
    assign idx_o = idx_q;
    assign last_o = busy_q && (left_q == 16'h0001);
endmodule : mbfd_walker

//--- testbench/mbfd_far.sv
// mbfd_far: register store and master write data facing the decoder
// assumes reads are answered in the same cycle; contents are not reset
`timescale 1ns/1ps
module mbfd_far (
    // clock
    input wire logic mclk_i,
    // store side
    input wire logic reg_bit_i,
    input wire logic reg_rd_i,
    input wire logic reg_we_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // write data side
    input wire logic [15:0] wr_idx_i,
    output logic [15:0] wr_word_o,
    output logic wr_bit_o
);
    logic [15:0] words [0:65535];
    logic bits [0:65535];
    int n_we = 0;
    int n_rd = 0;
    logic [15:0] rd_word;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            words[i] = 16'h5a5a ^ 16'(i);
            bits[i] = i[0] ^ i[3];
        end
    end
    assign wr_word_o = 16'hc300 ^ wr_idx_i;
    assign wr_bit_o = ~wr_idx_i[0] ^ wr_idx_i[2];
    // undriven read bus shows the inverse so stale data never matches
    assign rd_word = reg_bit_i ? {15'h0, bits[reg_addr_i]}
                               : words[reg_addr_i];
    assign reg_rdata_o = reg_rd_i ? rd_word : ~rd_word;
    always @(posedge mclk_i) begin
        if (reg_rd_i)
            n_rd++;
        if (reg_we_i) begin
            n_we++;
            // blocking is safe: reads and writes never share a cycle
            if (reg_bit_i)
                bits[reg_addr_i] = reg_wdata_i[0];
            else
                words[reg_addr_i] = reg_wdata_i;
        end
    end
endmodule : mbfd_far

//--- testbench/tb_top.sv
// tb_top: directed scenarios for the request decoder
// assumes mbfd_far as store; inputs change on the falling edge
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("ERROR %0t: got %h exp %h", $time, got, exp); \
    end \
end
module tb_top;
    import mbfd_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic rsp_ready_i = 1'b0;
    logic [7:0] req_func_i = 8'h00;
    logic [15:0] req_addr_i = 16'h0000;
    logic [15:0] req_qty_i = 16'h0000;
    logic [7:0] req_bytes_i = 8'h00;
    logic [15:0] req_value_i = 16'h0000;
    logic req_ready_o, reg_bit_o, reg_rd_o, reg_we_o, rd_valid_o;
    logic rsp_valid_o, rsp_exc_o, wr_bit_i;
    logic [15:0] wr_idx_o, wr_word_i, reg_addr_o, reg_wdata_o;
    logic [15:0] reg_rdata_i, rd_data_o;
    logic [7:0] rsp_func_o, rsp_code_o;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    always #5 mclk_i = ~mclk_i;

    mbfd_decoder DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_func_i(req_func_i), .req_addr_i(req_addr_i),
        .req_qty_i(req_qty_i), .req_bytes_i(req_bytes_i),
        .req_value_i(req_value_i), .wr_idx_o(wr_idx_o),
        .wr_word_i(wr_word_i), .wr_bit_i(wr_bit_i), .reg_bit_o(reg_bit_o),
        .reg_rd_o(reg_rd_o), .reg_we_o(reg_we_o), .reg_addr_o(reg_addr_o),
        .reg_wdata_o(reg_wdata_o), .reg_rdata_i(reg_rdata_i),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i),
        .rsp_func_o(rsp_func_o), .rsp_exc_o(rsp_exc_o),
        .rsp_code_o(rsp_code_o));

    mbfd_far FAR (.mclk_i(mclk_i), .reg_bit_i(reg_bit_o),
        .reg_rd_i(reg_rd_o), .reg_we_i(reg_we_o), .reg_addr_i(reg_addr_o),
        .reg_wdata_i(reg_wdata_o), .reg_rdata_o(reg_rdata_i),
        .wr_idx_i(wr_idx_o), .wr_word_o(wr_word_i), .wr_bit_o(wr_bit_i));

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // one request, read items checked in order, response header judged
    task automatic op(input logic [7:0] f, input logic [15:0] a,
                      input logic [15:0] q, input logic [7:0] nb,
                      input logic [15:0] v, input logic [7:0] ex);
        int k;
        int we0;
        int nrd;
        int nwe;
        int rd0;
        logic [15:0] e;
        k = 0;
        we0 = FAR.n_we;
        rd0 = FAR.n_rd;
        nrd = (ex == 8'h00 && f <= 8'h03) ? int'(q) : 0;
        nwe = (ex != 8'h00) ? 0 : (f == 8'h05 || f == 8'h06) ? 1 :
              (f == 8'h0f || f == 8'h10) ? int'(q) : 0;
        @(negedge mclk_i);
        req_valid_i = 1'b1;
        req_func_i = f;
        req_addr_i = a;
        req_qty_i = q;
        req_bytes_i = nb;
        req_value_i = v;
        @(negedge mclk_i);
        req_valid_i = 1'b0;
        repeat (400) begin
            if (rd_valid_o === 1'b1) begin
                e = a + 16'(k);
                e = (f == 8'h03) ? (16'h5a5a ^ e) : {15'h0, e[0] ^ e[3]};
                `CHK(rd_data_o, e)
                k++;
            end
            if (rsp_valid_o === 1'b1)
                break;
            @(negedge mclk_i);
        end
        `CHK(rsp_valid_o, 1'b1)
        `CHK(rsp_func_o, (ex != 8'h00) ? (f | 8'h80) : f)
        `CHK(rsp_exc_o, ex != 8'h00)
        `CHK(rsp_code_o, ex)
        `CHK(k, nrd)
        `CHK(FAR.n_we - we0, nwe)
        `CHK(FAR.n_rd - rd0, nrd)
        rsp_ready_i = 1'b1;
        @(negedge mclk_i);
        rsp_ready_i = 1'b0;
        `CHK(req_ready_o, 1'b1)
    endtask : op

    task automatic t_reads();
        op(8'h01, 16'h0100, 16'h0100, 8'h00, 16'h0000, 8'h00);
        op(8'h02, 16'h0007, 16'h0001, 8'h00, 16'h0000, 8'h00);
        op(8'h03, 16'h0200, 16'h0064, 8'h00, 16'h0000, 8'h00);
        op(8'h03, 16'hfffd, 16'h0003, 8'h00, 16'h0000, 8'h00);
    endtask : t_reads

    task automatic t_writes();
        op(8'h05, 16'h3000, 16'h0001, 8'h00, 16'hff00, 8'h00);
        `CHK(FAR.bits[16'h3000], 1'b1)
        op(8'h05, 16'h3000, 16'h0001, 8'h00, 16'h0000, 8'h00);
        `CHK(FAR.bits[16'h3000], 1'b0)
        op(8'h06, 16'h3001, 16'h0001, 8'h00, 16'h1234, 8'h00);
        `CHK(FAR.words[16'h3001], 16'h1234)
        op(8'h0f, 16'h4000, 16'h0100, 8'h20, 16'h0000, 8'h00);
        for (int k = 0; k < 256; k++)
            `CHK(FAR.bits[16'h4000 + 16'(k)], ~k[0] ^ k[2])
        op(8'h10, 16'h5000, 16'h0064, 8'hc8, 16'h0000, 8'h00);
        for (int k = 0; k < 100; k++)
            `CHK(FAR.words[16'h5000 + 16'(k)], 16'hc300 ^ 16'(k))
    endtask : t_writes

    task automatic t_limits();
        op(8'h01, 16'h0000, 16'h0101, 8'h00, 16'h0000, 8'h03);
        op(8'h02, 16'h0000, 16'h0000, 8'h00, 16'h0000, 8'h03);
        op(8'h03, 16'h0000, 16'h0065, 8'h00, 16'h0000, 8'h03);
        op(8'h0f, 16'h6000, 16'h0101, 8'h21, 16'h0000, 8'h03);
        op(8'h0f, 16'h6000, 16'h0009, 8'h01, 16'h0000, 8'h03);
        op(8'h10, 16'h6000, 16'h0065, 8'hca, 16'h0000, 8'h03);
        op(8'h10, 16'h6000, 16'h0002, 8'h03, 16'h0000, 8'h03);
        op(8'h05, 16'h6000, 16'h0001, 8'h00, 16'h1234, 8'h03);
        `CHK(FAR.words[16'h6000], 16'h5a5a ^ 16'h6000)
        `CHK(FAR.bits[16'h6000], 1'b0)
    endtask : t_limits

    task automatic t_excepts();
        logic [7:0] bad [8];
        bad = '{8'h00, 8'h04, 8'h07, 8'h08, 8'h11, 8'h17, 8'h2b, 8'hff};
        foreach (bad[i])
            op(bad[i], 16'h0000, 16'h0001, 8'h00, 16'h0000, 8'h01);
        op(8'h03, 16'hffff, 16'h0002, 8'h00, 16'h0000, 8'h02);
        op(8'h0f, 16'hfff8, 16'h0010, 8'h02, 16'h0000, 8'h02);
        `CHK(FAR.bits[16'hfff8], 1'b1)
        op(8'h03, 16'hffff, 16'h0065, 8'h00, 16'h0000, 8'h03);
        op(8'h7f, 16'hffff, 16'h0000, 8'h00, 16'h0000, 8'h01);
    endtask : t_excepts

    // clock enable low: a held request must not be taken
    task automatic t_freeze();
        int we0;
        we0 = FAR.n_we;
        @(negedge mclk_i);
        ce_i = 1'b0;
        req_valid_i = 1'b1;
        req_func_i = 8'h06;
        req_addr_i = 16'h3002;
        req_qty_i = 16'h0001;
        req_value_i = 16'hbeef;
        repeat (3) @(negedge mclk_i);
        `CHK(req_ready_o, 1'b1)
        `CHK(rsp_valid_o, 1'b0)
        `CHK(FAR.n_we - we0, 0)
        req_valid_i = 1'b0;
        ce_i = 1'b1;
        op(8'h06, 16'h3002, 16'h0001, 8'h00, 16'hbeef, 8'h00);
        `CHK(FAR.words[16'h3002], 16'hbeef)
    endtask : t_freeze

    // reset in mid-read: outputs drop to idle, next request served
    task automatic t_reset();
        @(negedge mclk_i);
        req_valid_i = 1'b1;
        req_func_i = 8'h03;
        req_addr_i = 16'h0200;
        req_qty_i = 16'h0064;
        @(negedge mclk_i);
        req_valid_i = 1'b0;
        repeat (5) @(negedge mclk_i);
        `CHK(req_ready_o, 1'b0)
        rst_n_i = 1'b0;
        @(negedge mclk_i);
        `CHK(req_ready_o, 1'b1)
        `CHK(rsp_valid_o, 1'b0)
        `CHK(rd_valid_o, 1'b0)
        `CHK(reg_rd_o, 1'b0)
        rst_n_i = 1'b1;
        op(8'h03, 16'h0204, 16'h0002, 8'h00, 16'h0000, 8'h00);
    endtask : t_reset

    // ceiling well above the under one thousand cycles the scenarios need
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles >= 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(negedge mclk_i);
        rst_n_i = 1'b1;
        t_reads();
        t_writes();
        t_limits();
        t_excepts();
        t_freeze();
        t_reset();
        end_of_test();
    end
endmodule : tb_top
